// >>> lsbu_defines.svh
// Constants of the logic, shift and bit unit.
`ifndef LSBU_DEFINES_SVH
`define LSBU_DEFINES_SVH

// ****************************************
// Operand widths and masks
// ****************************************
`define LSBU_DATA_W     32
`define LSBU_MASK_BYTE  32'h0000_00FF
`define LSBU_MASK_WORD  32'h0000_FFFF
`define LSBU_MASK_LONG  32'hFFFF_FFFF
`define LSBU_MSB_BYTE   5'h07
`define LSBU_MSB_WORD   5'h0F
`define LSBU_MSB_LONG   5'h1F

// ****************************************
// Shift distances
// ****************************************
`define LSBU_DIST_1     3'h0
`define LSBU_DIST_2     3'h1
`define LSBU_DIST_4     3'h2
`define LSBU_DIST_8     3'h3
`define LSBU_DIST_16    3'h4
`define LSBU_AMT_W      5
`define LSBU_MAX_STEPS  31

// ****************************************
// Bit manipulation
// ****************************************
`define LSBU_BITNUM_W   3

`endif

// >>> lsbu_pkg.sv
// Types of the logic, shift and bit unit.
package lsbu_pkg;

  typedef enum logic [3:0] {
    logic_and_op          = 4'h0,
    logic_or_op           = 4'h1,
    logic_xor_op          = 4'h2,
    logic_not_op          = 4'h3,
    logical_shift_left_op = 4'h4,
    logical_shift_right_op = 4'h5,
    arith_shift_left_op   = 4'h6,
    arith_shift_right_op  = 4'h7,
    rotate_left_op        = 4'h8,
    rotate_right_op       = 4'h9,
    rotate_carry_left_op  = 4'hA,
    rotate_carry_right_op = 4'hB,
    bit_force_one_op      = 4'hC,
    cond_bit_force_one_op = 4'hD,
    bit_force_zero_op     = 4'hE
  } lsbu_op_t;

  typedef enum logic [1:0] {
    lsbu_size_byte = 2'h0,
    lsbu_size_word = 2'h1,
    lsbu_size_long = 2'h2
  } lsbu_size_t;

  typedef struct packed {
    logic        valid;
    lsbu_op_t    op;
    lsbu_size_t  size;
    logic        dst_is_mem;
    logic        use_imm;
    logic [31:0] immediate_operand;
    logic [31:0] dst_operand;
    logic [31:0] source_operand;
    logic        dist_var;
    logic [2:0]  dist_code;
    logic        cond_on_zero_set;
    logic        carry_in;
    logic        zero_in;
  } lsbu_req_t;

  typedef struct packed {
    logic        valid;
    logic        write_en;
    logic        err;
    logic        flags_we;
    logic        carry;
    logic        zero;
    logic        negative;
    logic [31:0] data;
  } lsbu_resp_t;

  typedef struct packed {
    lsbu_resp_t resp;
  } lsbu_state_t;

endpackage

// >>> lsbu_unit.sv
// Logic, shift and bit manipulation datapath.
`timescale 1ns/1ps
`include "lsbu_defines.svh"

// Summary of operation
// - AND destination with immediate or source.
// - OR destination with immediate or source.
// - XOR destination with immediate or source.
// - Invert all bits of the operand size, store in place.
// - Logical shift by 1,2,4,8,16, zero fill.
// - Register logical shifts take any 5-bit distance.
// - Arithmetic shift by one or two, sign kept on right shifts only.
// - Rotate by one or two positions.
// - Rotate through carry by one or two.
// - Set selected byte bit to one.
// - Conditional set on memory byte only.
// - Condition comes from the zero flag.
// - Clear selected byte bit to zero.
module lsbu_unit
  import lsbu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire lsbu_req_t  req,
  output lsbu_resp_t      resp
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Returns the mask that covers the operand size.
  function automatic logic [31:0] size_mask(input lsbu_size_t sz);
    case (sz)
      lsbu_size_byte: size_mask = `LSBU_MASK_BYTE;
      lsbu_size_word: size_mask = `LSBU_MASK_WORD;
      default:        size_mask = `LSBU_MASK_LONG;
    endcase
  endfunction

  // Returns the index of the operand's sign bit.
  function automatic logic [4:0] size_msb(input lsbu_size_t sz);
    case (sz)
      lsbu_size_byte: size_msb = `LSBU_MSB_BYTE;
      lsbu_size_word: size_msb = `LSBU_MSB_WORD;
      default:        size_msb = `LSBU_MSB_LONG;
    endcase
  endfunction

  // Picks the bit number from the immediate or a register.
  function automatic logic [2:0] bit_num(input logic use_imm,
                                         input logic [31:0] imm,
                                         input logic [31:0] src);
    if (use_imm)
    begin
      bit_num = imm[`LSBU_BITNUM_W-1:0];
    end
    else
    begin
      bit_num = src[`LSBU_BITNUM_W-1:0];
    end
  endfunction

  // Returns a one-hot mask for the selected bit of the byte.
  function automatic logic [31:0] bit_mask(input logic [2:0] bn);
    bit_mask = 32'h0000_0001 << bn;
  endfunction

  // Writes the result into the kept bits and leaves the others alone.
  function automatic logic [31:0] merge(input logic [31:0] dst,
                                        input logic [31:0] res,
                                        input logic [31:0] keep);
    merge = (dst & ~keep) | (res & keep);
  endfunction

  // Shifts or rotates a masked value by one position; returns {carry, value}.
  function automatic logic [32:0] step(input lsbu_op_t op,
                                       input logic [31:0] val,
                                       input logic cin,
                                       input logic [4:0] msbi,
                                       input logic [31:0] msk);
    logic        top;
    logic        ins;
    logic [31:0] v;
    top = val[msbi];
    ins = 1'h0;
    v   = 32'h0000_0000;
    case (op)
      logical_shift_left_op, arith_shift_left_op:
      begin
        v    = (val << 1) & msk;
        step = {top, v};
      end
      rotate_left_op:
      begin
        v    = ((val << 1) | {31'h0000_0000, top}) & msk;
        step = {top, v};
      end
      rotate_carry_left_op:
      begin
        v    = ((val << 1) | {31'h0000_0000, cin}) & msk;
        step = {top, v};
      end
      logical_shift_right_op, arith_shift_right_op, rotate_right_op, rotate_carry_right_op:
      begin
        case (op)
          arith_shift_right_op:  ins = top;
          rotate_right_op:       ins = val[0];
          rotate_carry_right_op: ins = cin;
          default:               ins = 1'h0;
        endcase
        v    = (val >> 1) | ({31'h0000_0000, ins} << msbi);
        step = {val[0], v & msk};
      end
      default:
      begin
        step = {cin, val};
      end
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  lsbu_state_t st_ff;
  lsbu_state_t nxt_st;

  logic [31:0] msk;
  logic [4:0]  msbi;
  logic [31:0] opnd;
  logic [31:0] dval;
  logic [31:0] lres;
  logic [4:0]  amt;
  logic        is_shift;
  logic        is_short;
  logic        bad;
  logic        carry;
  logic [32:0] sh;
  logic [2:0]  bnum;
  logic        cond_ok;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_st   = st_ff;
    msk      = size_mask(req.size);
    msbi     = size_msb(req.size);
    opnd     = req.use_imm ? req.immediate_operand : req.source_operand;
    dval     = req.dst_operand & msk;
    lres     = 32'h0000_0000;
    amt      = 5'h01;
    bad      = 1'h0;
    carry    = 1'h0;
    sh       = 33'h0_0000_0000;
    bnum     = bit_num(req.use_imm, req.immediate_operand, req.source_operand);
    cond_ok  = 1'h0;
    is_shift = (req.op >= logical_shift_left_op) && (req.op <= rotate_carry_right_op);
    is_short = (req.op >= arith_shift_left_op) && (req.op <= rotate_carry_right_op);

    // ****************************************
    // Default response
    // ****************************************
    nxt_st.resp.valid    = req.valid;
    nxt_st.resp.write_en = 1'h0;
    nxt_st.resp.err      = 1'h0;
    nxt_st.resp.flags_we = 1'h0;
    nxt_st.resp.carry    = req.carry_in;
    nxt_st.resp.zero     = req.zero_in;
    nxt_st.resp.negative = 1'h0;
    nxt_st.resp.data     = req.dst_operand;

    // ****************************************
    // Shift distance selection
    // ****************************************
    if (req.dist_var)
    begin
      amt = req.use_imm ? req.immediate_operand[`LSBU_AMT_W-1:0]
                        : req.source_operand[`LSBU_AMT_W-1:0];
      bad = req.dst_is_mem || is_short;
    end
    else
    begin
      case (req.dist_code)
        `LSBU_DIST_1:  amt = 5'h01;
        `LSBU_DIST_2:  amt = 5'h02;
        `LSBU_DIST_4:  amt = 5'h04;
        `LSBU_DIST_8:  amt = 5'h08;
        `LSBU_DIST_16: amt = 5'h10;
        default:       bad = 1'h1;
      endcase
      if (is_short && (req.dist_code > `LSBU_DIST_2))
      begin
        bad = 1'h1;
      end
    end

    // ****************************************
    // Shift and rotate datapath
    // ****************************************
    sh = {1'h0, dval};
    if (is_shift)
    begin
      sh = {req.carry_in, dval};
      for (int i = 0; i < `LSBU_MAX_STEPS; i++)
      begin
        if (i < int'(amt))
        begin
          sh = step(req.op, sh[31:0], sh[32], msbi, msk);
        end
      end
      carry = (amt == 5'h00) ? 1'h0 : sh[32];
    end

    // ****************************************
    // Logic and bit results
    // ****************************************
    case (req.op)
      logic_and_op:          lres = req.dst_operand & opnd;
      logic_or_op:           lres = req.dst_operand | opnd;
      logic_xor_op:          lres = req.dst_operand ^ opnd;
      logic_not_op:          lres = ~req.dst_operand;
      bit_force_one_op:      lres = req.dst_operand | bit_mask(bnum);
      cond_bit_force_one_op: lres = req.dst_operand | bit_mask(bnum);
      bit_force_zero_op:     lres = req.dst_operand & ~bit_mask(bnum);
      default:               lres = sh[31:0];
    endcase

    // ****************************************
    // Response and flags
    // ****************************************
    if (req.valid)
    begin
      case (req.op)
        logic_and_op, logic_or_op, logic_xor_op, logic_not_op:
        begin
          nxt_st.resp.data     = merge(req.dst_operand, lres, msk);
          nxt_st.resp.write_en = 1'h1;
          nxt_st.resp.flags_we = 1'h1;
          nxt_st.resp.zero     = ((lres & msk) == 32'h0000_0000);
          nxt_st.resp.negative = lres[msbi];
        end
        bit_force_one_op, bit_force_zero_op:
        begin
          nxt_st.resp.data     = merge(req.dst_operand, lres, `LSBU_MASK_BYTE);
          nxt_st.resp.write_en = 1'h1;
        end
        cond_bit_force_one_op:
        begin
          cond_ok = (req.zero_in == req.cond_on_zero_set);
          if (!req.dst_is_mem)
          begin
            nxt_st.resp.err = 1'h1;
          end
          else if (cond_ok)
          begin
            nxt_st.resp.data     = merge(req.dst_operand, lres, `LSBU_MASK_BYTE);
            nxt_st.resp.write_en = 1'h1;
          end
        end
        logical_shift_left_op, logical_shift_right_op, arith_shift_left_op, arith_shift_right_op,
        rotate_left_op, rotate_right_op, rotate_carry_left_op, rotate_carry_right_op:
        begin
          if (bad)
          begin
            nxt_st.resp.err = 1'h1;
          end
          else
          begin
            nxt_st.resp.data     = merge(req.dst_operand, lres, msk);
            nxt_st.resp.write_en = 1'h1;
            nxt_st.resp.flags_we = 1'h1;
            nxt_st.resp.carry    = carry;
            nxt_st.resp.zero     = ((lres & msk) == 32'h0000_0000);
            nxt_st.resp.negative = lres[msbi];
          end
        end
        default:
        begin
          nxt_st.resp.err = 1'h1;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Output
  // ****************************************
  assign resp = st_ff.resp;

endmodule // lsbu_unit

// >>> lsbu_issuer.sv
// Issuing stage model that presents requests to the unit.
`timescale 1ns/1ps
module lsbu_issuer
  import lsbu_pkg::*;
(
  input  wire logic clk,
  output lsbu_req_t req
);
  initial req = '0;
  task automatic issue(input lsbu_req_t r);
    lsbu_req_t t;
    @(negedge clk);
    req = r;
    @(negedge clk);
    t = ~r;
    t.valid = 1'b0;
    req = t;
  endtask
endmodule // lsbu_issuer

// >>> lsbu_unit_asserts.sv
// Checker of the logic, shift and bit unit.
`timescale 1ns/1ps
module lsbu_unit_asserts
  import lsbu_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire lsbu_req_t  req,
  input wire lsbu_resp_t resp
);
  logic [31:0] dst;
  logic [2:0]  bitn;
  assign dst = req.dst_operand;
  assign bitn = req.use_imm ? req.immediate_operand[2:0] : req.source_operand[2:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_answer_one_cycle: assert property (req.valid |=> resp.valid)
    else $error("request got no answer");
  a_idle_quiet: assert property (!req.valid |=> !resp.valid && !resp.write_en && !resp.err && !resp.flags_we)
    else $error("answer without request");
  a_xor_long: assert property (req.valid && req.op == logic_xor_op && req.size == lsbu_size_long && req.use_imm
    |=> resp.data == ($past(dst) ^ $past(req.immediate_operand))) else $error("wrong xor");
  a_not_byte: assert property (req.valid && req.op == logic_not_op
    |=> resp.write_en && resp.data[7:0] == ~$past(dst[7:0])) else $error("wrong complement");
  a_shr_carry: assert property (req.valid && req.op == logical_shift_right_op && req.size == lsbu_size_long
    && !req.dist_var && req.dist_code == 3'h0 |=> resp.flags_we && resp.carry == $past(dst[0])
    && resp.data == $past(dst) >> 1) else $error("wrong shift by one");
  a_var_mem_refused: assert property (req.valid && req.dist_var && req.dst_is_mem
    |=> resp.err && !resp.write_en && !resp.flags_we) else $error("memory variable shift taken");
  a_sign_kept: assert property (req.valid && req.op == arith_shift_right_op && req.size == lsbu_size_byte
    && !req.dist_var && req.dist_code < 3'h2 |=> resp.data[7] == $past(dst[7])) else $error("sign lost");
  a_set_bit: assert property (req.valid && req.op == bit_force_one_op
    |=> resp.data[7:0] == ($past(dst[7:0]) | (8'h01 << $past(bitn)))) else $error("wrong bit set");
  a_clear_bit: assert property (req.valid && req.op == bit_force_zero_op
    |=> resp.data[7:0] == ($past(dst[7:0]) & ~(8'h01 << $past(bitn)))) else $error("wrong bit clear");
  a_cond_false_skip: assert property (req.valid && req.op == cond_bit_force_one_op && req.dst_is_mem
    && req.zero_in != req.cond_on_zero_set |=> resp.valid && !resp.write_en && !resp.err)
    else $error("false condition wrote");
  c_rotate_carry: cover property (req.valid && req.op == rotate_carry_right_op);
  c_refused: cover property (resp.err);
  c_cond_skip: cover property (resp.valid && !resp.write_en && !resp.err);
endmodule // lsbu_unit_asserts
bind lsbu_unit lsbu_unit_asserts i_chk (.clk(clk), .resetn(resetn), .req(req), .resp(resp));

// >>> lsbu_unit_tb.sv
// Self-checking testbench of the logic, shift and bit unit.
`timescale 1ns/1ps
module lsbu_unit_tb
  import lsbu_pkg::*;
  ();
  logic       clk;
  logic       resetn;
  lsbu_req_t  req;
  lsbu_resp_t resp;
  lsbu_req_t  q;
  int         n_errors;
  int         comparisons;
  int         d;

  lsbu_unit i_dut (.clk(clk), .resetn(resetn), .req(req), .resp(resp));
  lsbu_issuer i_prt (.clk(clk), .req(req));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic lsbu_req_t mk(input lsbu_op_t o, input lsbu_size_t s, input logic [31:0] dv,
                                   input logic [31:0] v);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = o;
    mk.size = s;
    mk.use_imm = 1'b1;
    mk.dst_operand = dv;
    mk.immediate_operand = v;
    mk.source_operand = ~v;
  endfunction

  // Expected flags are write enable, error and carry.
  task automatic go(input lsbu_req_t r, input logic [31:0] ed, input logic [2:0] ef);
    int          sb;
    logic [31:0] lo;
    sb = (r.size == lsbu_size_byte) ? 7 : ((r.size == lsbu_size_word) ? 15 : 31);
    lo = ed << (31 - sb);
    i_prt.issue(r);
    cmp({resp.valid, resp.write_en, resp.err, resp.carry}, {1'b1, ef});
    if (!ef[1])
      cmp(resp.data, ed);
    if (ef[2] && (r.op < bit_force_one_op))
      cmp({resp.flags_we, resp.zero, resp.negative}, {1'b1, lo == 32'h0, lo[31]});
    else
      cmp({resp.flags_we, resp.zero, resp.negative}, {1'b0, r.zero_in, 1'b0});
  endtask

  task automatic t_logic;
    q = mk(logic_and_op, lsbu_size_byte, 32'h1234_56F0, 32'h0);
    q.use_imm = 1'b0;
    q.source_operand = 32'hAAAA_AA3C;
    go(q, 32'h1234_5630, 3'h4);
    go(mk(logic_or_op, lsbu_size_word, 32'h1234_0F00, 32'hFFFF_00F0), 32'h1234_0FF0, 3'h4);
    go(mk(logic_xor_op, lsbu_size_long, 32'hFFFF_0000, 32'h0F0F_0F0F), 32'hF0F0_0F0F, 3'h4);
    q = mk(logic_not_op, lsbu_size_byte, 32'h1234_5601, 32'h0);
    q.dst_is_mem = 1'b1;
    go(q, 32'h1234_56FE, 3'h4);
  endtask

  task automatic t_shift;
    go(mk(logical_shift_left_op, lsbu_size_byte, 32'hAAAA_AA81, 32'h0), 32'hAAAA_AA02, 3'h5);
    for (int i = 0; i < 5; i++)
    begin
      d = 1 << i;
      q = mk(logical_shift_right_op, lsbu_size_long, 32'h8001_8001, 32'h0);
      q.dist_code = i[2:0];
      go(q, 32'h8001_8001 >> d, {2'h2, q.dst_operand[d - 1]});
    end
    q.dist_code = 3'h5;
    go(q, 32'h0, 3'h2);
    q = mk(logical_shift_left_op, lsbu_size_long, 32'h0000_0003, 32'h0000_0004);
    q.dist_var = 1'b1;
    go(q, 32'h0000_0030, 3'h4);
    q.use_imm = 1'b0;
    q.source_operand = 32'h0000_001F;
    go(q, 32'h8000_0000, 3'h5);
    q.dst_is_mem = 1'b1;
    go(q, 32'h0, 3'h2);
  endtask

  task automatic t_rotate;
    q = mk(arith_shift_right_op, lsbu_size_byte, 32'h0000_0086, 32'h0);
    q.dist_code = 3'h1;
    go(q, 32'h0000_00E1, 3'h5);
    q.dist_code = 3'h2;
    go(q, 32'h0, 3'h2);
    q = mk(rotate_left_op, lsbu_size_word, 32'h5555_C001, 32'h0);
    q.dist_code = 3'h1;
    go(q, 32'h5555_0007, 3'h5);
    q = mk(rotate_carry_right_op, lsbu_size_byte, 32'h0000_0003, 32'h0);
    q.dist_code = 3'h1;
    go(q, 32'h0000_0080, 3'h5);
    q = mk(rotate_carry_left_op, lsbu_size_byte, 32'h0000_0080, 32'h0);
    q.carry_in = 1'b1;
    go(q, 32'h0000_0001, 3'h5);
    q = mk(arith_shift_left_op, lsbu_size_byte, 32'h0000_0041, 32'h0);
    q.dist_code = 3'h1;
    go(q, 32'h0000_0004, 3'h5);
    q = mk(rotate_right_op, lsbu_size_long, 32'h0000_0001, 32'h0);
    go(q, 32'h8000_0000, 3'h5);
    q.dist_var = 1'b1;
    go(q, 32'h0, 3'h2);
    q.dist_var = 1'b0;
    q.op = lsbu_op_t'(4'hF);
    go(q, 32'h0, 3'h2);
  endtask

  task automatic t_bits;
    q = mk(bit_force_one_op, lsbu_size_long, 32'h1234_5610, 32'h0000_0007);
    q.use_imm = 1'b0;
    go(q, 32'h1234_5611, 3'h4);
    go(mk(bit_force_zero_op, lsbu_size_long, 32'h0000_00FF, 32'h0000_0007), 32'h0000_007F, 3'h4);
    q = mk(cond_bit_force_one_op, lsbu_size_byte, 32'h0000_0000, 32'h0000_0003);
    q.dst_is_mem = 1'b1;
    q.cond_on_zero_set = 1'b1;
    q.zero_in = 1'b1;
    go(q, 32'h0000_0008, 3'h4);
    q.zero_in = 1'b0;
    go(q, 32'h0, 3'h0);
    q.dst_is_mem = 1'b0;
    q.zero_in = 1'b1;
    go(q, 32'h0, 3'h2);
  endtask

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (1000) @(posedge clk);
    n_errors++;
    print_verdict;
  end

  initial
  begin
    n_errors = 0;
    comparisons = 0;
    resetn = 1'b0;
    repeat (20) @(negedge clk);
    cmp({resp.valid, resp.write_en, resp.err, resp.flags_we}, 32'h0);
    resetn = 1'b1;
    t_logic;
    t_shift;
    t_rotate;
    t_bits;
    print_verdict;
  end
endmodule // lsbu_unit_tb
